// >>> dic_pkg.sv
// What this block does
// - overflow flag clears on low counter read after flagged status access; alternate path never
// - capture flag two sets on falling edge of pin two; irq if enabled
// - capture flag two clears after status read then capture two low read
// - compare flag two sets on compare two match; irq if compare enable
// - compare flag two clears after status read then compare two low access
// - one capture irq enable gates both capture flags
// - capture register one loads counter on selected pin one edge, sets flag one
// - capture one high byte at 0x14, low byte at 0x15
// - captured value is counter before the edge plus one, from synchronisation
// - resolution one count; counter steps every four bus clocks
// - capture one loads on every valid edge not held off by a high byte read, regardless of flag one
// - reading capture one high blocks transfers until its low byte is read
// - reading a capture low byte never blocks a transfer
// - reset leaves capture register one contents unchanged except leaving stop
// - capture register two loads counter only on pin two falling edge, sets flag two
// - capture two high byte at 0x1c, low byte at 0x1d
// - reading capture two high blocks transfers until its low byte is read
// - capture two loads on every falling edge not held off by a high byte read, regardless of flag two
// - reset leaves capture register two contents unchanged except leaving stop
// - edge select one means rising edge on pin one, zero means falling
// - capture flag one clears after status read then capture one low read
// - status read arms clearing, a status write only for overflow; each flag clears on a read of its own register, compare two on any access
package dic_pkg;
  localparam logic [7:0] DIC_ADDR_CTRL     = 8'h12;
  localparam logic [7:0] DIC_ADDR_STATUS   = 8'h13;
  localparam logic [7:0] DIC_ADDR_CAP1_HI  = 8'h14;
  localparam logic [7:0] DIC_ADDR_CAP1_LO  = 8'h15;
  localparam logic [7:0] DIC_ADDR_CNT_LO   = 8'h19;
  localparam logic [7:0] DIC_ADDR_ACNT_LO  = 8'h1b;
  localparam logic [7:0] DIC_ADDR_CAP2_HI  = 8'h1c;
  localparam logic [7:0] DIC_ADDR_CAP2_LO  = 8'h1d;
  localparam logic [7:0] DIC_ADDR_CMP2_LO  = 8'h1f;
  // control register fields
  localparam int DIC_CTRL_CAP_IE_BIT = 7;
  localparam int DIC_CTRL_CMP_IE_BIT = 6;
  localparam int DIC_CTRL_EDGE1_BIT  = 1;
  // status register fields
  localparam int DIC_STAT_CAP1_BIT  = 7;
  localparam int DIC_STAT_OVF_BIT   = 5;
  localparam int DIC_STAT_CAP2_BIT  = 4;
  localparam int DIC_STAT_CMP2_BIT  = 3;
  localparam logic DIC_FLAG_RST = 1'b0;
  localparam int DIC_SYNC_STAGES = 2;
endpackage

// >>> dic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dic_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o,
  output logic      rise_o
);
  import dic_pkg::*;
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic [DIC_SYNC_STAGES:0] live_r;
  // ********************************
  // two-stage synchroniser, then edge
  // ********************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  // edges held off until the pipe holds real pin samples: a pin sitting
  // low through reset would otherwise look like a falling edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      live_r <= {(DIC_SYNC_STAGES + 1){1'b0}};
    end else begin
      live_r <= {live_r[DIC_SYNC_STAGES-1:0], 1'b1};
    end
  end
  assign level_o = sync_r;
  assign fall_o  = live_r[DIC_SYNC_STAGES] & prev_r & ~sync_r;
  assign rise_o  = live_r[DIC_SYNC_STAGES] & ~prev_r & sync_r;
endmodule
`default_nettype wire

// >>> dic_capture.sv
`timescale 1ns/1ps
`default_nettype none
module dic_capture (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        stop_exit_i,
  input  wire logic [15:0] counter_i,
  input  wire logic        compare2_match_i,
  input  wire logic        overflow_i,
  input  wire logic        capture_pin_one_i,
  input  wire logic        capture_pin_two_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_wr_i,
  input  wire logic [7:0]  bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  output logic [7:0]       bus_rdata_o,
  output logic             capture_flag_one_o,
  output logic             capture_flag_two_o,
  output logic             compare_flag_two_o,
  output logic             overflow_flag_o,
  output logic             capture_irq_o,
  output logic             compare_irq_o,
  output logic [7:0]       timer_control_register_o
);
  import dic_pkg::*;

  // ********************************
  // pin synchronisation
  // ********************************
  logic p1_fall;
  logic p1_rise;
  logic p2_fall;

  dic_sync u_sync1 (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .pin_i  (capture_pin_one_i),
    .level_o(),
    .fall_o (p1_fall),
    .rise_o (p1_rise)
  );

  dic_sync u_sync2 (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .pin_i  (capture_pin_two_i),
    .level_o(),
    .fall_o (p2_fall),
    .rise_o ()
  );

  // ********************************
  // control register
  // ********************************
  logic [7:0] ctrl_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= 8'h00;
    end else if (bus_wr_i && bus_addr_i == DIC_ADDR_CTRL) begin
      ctrl_r <= bus_wdata_i;
    end
  end
  assign timer_control_register_o = ctrl_r;

  logic edge_one_sel;
  logic cap_ie;
  logic cmp_ie;
  assign edge_one_sel = ctrl_r[DIC_CTRL_EDGE1_BIT];
  assign cap_ie       = ctrl_r[DIC_CTRL_CAP_IE_BIT];
  assign cmp_ie       = ctrl_r[DIC_CTRL_CMP_IE_BIT];

  // ********************************
  // capture events
  // ********************************
  logic cap1_evt;
  logic cap2_evt;
  assign cap1_evt = edge_one_sel ? p1_rise : p1_fall;
  assign cap2_evt = p2_fall;

  // decodes
  logic rd_stat;
  logic rd_c1hi;
  logic rd_c1lo;
  logic rd_c2hi;
  logic rd_c2lo;
  logic rd_cntlo;
  logic acc_cmp2lo;
  logic acc_stat;
  assign acc_stat   = (bus_rd_i || bus_wr_i) && bus_addr_i == DIC_ADDR_STATUS;
  assign rd_stat    = bus_rd_i && bus_addr_i == DIC_ADDR_STATUS;
  assign rd_c1hi    = bus_rd_i && bus_addr_i == DIC_ADDR_CAP1_HI;
  assign rd_c1lo    = bus_rd_i && bus_addr_i == DIC_ADDR_CAP1_LO;
  assign rd_c2hi    = bus_rd_i && bus_addr_i == DIC_ADDR_CAP2_HI;
  assign rd_c2lo    = bus_rd_i && bus_addr_i == DIC_ADDR_CAP2_LO;
  assign rd_cntlo   = bus_rd_i && bus_addr_i == DIC_ADDR_CNT_LO;
  assign acc_cmp2lo = (bus_rd_i || bus_wr_i) && bus_addr_i == DIC_ADDR_CMP2_LO;

  // ********************************
  // transfer inhibit after high byte read
  // ********************************
  logic inh1_r;
  logic inh2_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      inh1_r <= 1'b0;
    end else if (rd_c1hi) begin
      inh1_r <= 1'b1;
    end else if (rd_c1lo) begin
      inh1_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      inh2_r <= 1'b0;
    end else if (rd_c2hi) begin
      inh2_r <= 1'b1;
    end else if (rd_c2lo) begin
      inh2_r <= 1'b0;
    end
  end

  // ********************************
  // capture registers: not reset, only cleared on stop exit
  // ********************************
  logic [15:0] capture_register_one_r;
  logic [15:0] capture_register_two_r;
  logic [15:0] cnt_plus1;
  logic [15:0] cnt_d1_r;
  logic [15:0] cnt_d2_r;
  logic        cap1_ld;
  logic        cap2_ld;
  // counter delayed as deep as the pin synchroniser, so the value is the one
  // current when the pin moved; plus one for the count the sync costs
  always_ff @(posedge clk_i) begin
    cnt_d1_r <= counter_i;
    cnt_d2_r <= cnt_d1_r;
  end
  assign cnt_plus1 = cnt_d2_r + 16'h0001;
  // a low-byte read lifts the inhibit in its own cycle: read and transfer
  // never block each other; no transfer while reset is held
  assign cap1_ld = rst_n_i && cap1_evt && (!inh1_r || rd_c1lo);
  assign cap2_ld = rst_n_i && cap2_evt && (!inh2_r || rd_c2lo);
  always_ff @(posedge clk_i) begin
    if (stop_exit_i) begin
      capture_register_one_r <= 16'h0000;
    end else if (cap1_ld) begin
      capture_register_one_r <= cnt_plus1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (stop_exit_i) begin
      capture_register_two_r <= 16'h0000;
    end else if (cap2_ld) begin
      capture_register_two_r <= cnt_plus1;
    end
  end

  // ********************************
  // flags with two-step clear
  // ********************************
  logic cap1_f_r;
  logic cap2_f_r;
  logic cmp2_f_r;
  logic ovf_f_r;
  logic arm1_r;
  logic arm2_r;
  logic armc_r;
  logic armo_r;

  // status read arms each set flag, a status write only the overflow flag; set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arm1_r <= 1'b0;
      arm2_r <= 1'b0;
      armc_r <= 1'b0;
      armo_r <= 1'b0;
    end else begin
      if (rd_stat && cap1_f_r) arm1_r <= 1'b1;
      else if (rd_c1lo) arm1_r <= 1'b0;
      if (rd_stat && cap2_f_r) arm2_r <= 1'b1;
      else if (rd_c2lo) arm2_r <= 1'b0;
      if (rd_stat && cmp2_f_r) armc_r <= 1'b1;
      else if (acc_cmp2lo) armc_r <= 1'b0;
      if (acc_stat && ovf_f_r) armo_r <= 1'b1;
      else if (rd_cntlo) armo_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cap1_f_r <= DIC_FLAG_RST;
    end else if (cap1_evt) begin
      cap1_f_r <= 1'b1;
    end else if (arm1_r && rd_c1lo) begin
      cap1_f_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cap2_f_r <= DIC_FLAG_RST;
    end else if (cap2_evt) begin
      cap2_f_r <= 1'b1;
    end else if (arm2_r && rd_c2lo) begin
      cap2_f_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp2_f_r <= DIC_FLAG_RST;
    end else if (compare2_match_i) begin
      cmp2_f_r <= 1'b1;
    end else if (armc_r && acc_cmp2lo) begin
      cmp2_f_r <= 1'b0;
    end
  end
  // alternate counter low is not decoded here, so it never clears
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_f_r <= DIC_FLAG_RST;
    end else if (overflow_i) begin
      ovf_f_r <= 1'b1;
    end else if (armo_r && rd_cntlo) begin
      ovf_f_r <= 1'b0;
    end
  end

  assign capture_flag_one_o = cap1_f_r;
  assign capture_flag_two_o = cap2_f_r;
  assign compare_flag_two_o = cmp2_f_r;
  assign overflow_flag_o    = ovf_f_r;
  assign capture_irq_o = cap_ie & (cap1_f_r | cap2_f_r);
  assign compare_irq_o = cmp_ie & cmp2_f_r;

  // ********************************
  // read data
  // ********************************
  logic [7:0] rdata_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (bus_rd_i) begin
      case (bus_addr_i)
        DIC_ADDR_CTRL:    rdata_r <= ctrl_r;
        DIC_ADDR_STATUS:  rdata_r <= {cap1_f_r, 1'b0, ovf_f_r, cap2_f_r, cmp2_f_r, 3'h0};
        DIC_ADDR_CAP1_HI: rdata_r <= capture_register_one_r[15:8];
        DIC_ADDR_CAP1_LO: rdata_r <= capture_register_one_r[7:0];
        DIC_ADDR_CAP2_HI: rdata_r <= capture_register_two_r[15:8];
        DIC_ADDR_CAP2_LO: rdata_r <= capture_register_two_r[7:0];
        default:          rdata_r <= 8'h00;
      endcase
    end
  end
  assign bus_rdata_o = rdata_r;
endmodule
`default_nettype wire

// >>> dic_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dic_pin_model (
  input  wire logic clk_i,
  output logic      pin_one_o,
  output logic      pin_two_o
);
  // ****
  // capture pin driver
  // ****
  // idle high, as an unused input with a pull-up
  initial begin
    pin_one_o = 1'b1;
    pin_two_o = 1'b1;
  end
  // hold sets how long the level stays: short or slow pulses
  task automatic step(input bit two, input logic lvl, input int hold);
    if (two) pin_two_o = lvl;
    else pin_one_o = lvl;
    repeat (hold) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> dic_capture_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dic_capture_checker
  import dic_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       compare2_match_i,
  input wire logic       capture_pin_one_i,
  input wire logic       capture_pin_two_i,
  input wire logic       bus_rd_i,
  input wire logic       bus_wr_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic       capture_flag_one_o,
  input wire logic       capture_flag_two_o,
  input wire logic       compare_flag_two_o,
  input wire logic       overflow_flag_o,
  input wire logic       capture_irq_o,
  input wire logic       compare_irq_o,
  input wire logic [7:0] timer_control_register_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****
  // flag and request relations
  // ****
  cap_irq_a:
    assert property (capture_irq_o == (timer_control_register_o[7] & (capture_flag_one_o | capture_flag_two_o)))
    else $error("capture irq wrong");
  cmp_irq_a:
    assert property (compare_irq_o == (timer_control_register_o[6] & compare_flag_two_o))
    else $error("compare irq wrong");
  cap2_set_a: assert property ($fell(capture_pin_two_i) |-> ##[2:4] capture_flag_two_o)
    else $error("flag two not set");
  cap1_edge_a:
    assert property ($rose(capture_flag_one_o) |-> $past(capture_pin_one_i, 2) != $past(capture_pin_one_i, 5))
    else $error("flag one without edge");
  cap2_clr_a:
    assert property ($fell(capture_flag_two_o) |-> $past(bus_rd_i) && $past(bus_addr_i) == DIC_ADDR_CAP2_LO)
    else $error("flag two cleared wrongly");
  cap1_clr_a:
    assert property ($fell(capture_flag_one_o) |-> $past(bus_rd_i) && $past(bus_addr_i) == DIC_ADDR_CAP1_LO)
    else $error("flag one cleared wrongly");
  cmp_set_a: assert property (compare2_match_i |=> compare_flag_two_o)
    else $error("compare flag not set");
  cmp_clr_a:
    assert property ($fell(compare_flag_two_o) |-> ($past(bus_rd_i) || $past(bus_wr_i)) && $past(bus_addr_i) == DIC_ADDR_CMP2_LO)
    else $error("compare flag cleared wrongly");
  ovf_clr_a:
    assert property ($fell(overflow_flag_o) |-> $past(bus_rd_i) && $past(bus_addr_i) == DIC_ADDR_CNT_LO)
    else $error("overflow flag cleared wrongly");
  cover property ($rose(capture_flag_one_o));
  cover property ($fell(capture_flag_two_o));
  cover property ($fell(overflow_flag_o));
endmodule
`default_nettype wire

// >>> dic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
  import dic_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        stop_exit_i = 1'b0;
  logic        cmp_m = 1'b0;
  logic        ovf = 1'b0;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [15:0] counter_i = 16'h0000;
  logic [7:0]  rdata, ctrl;
  logic        p1, p2, f1, f2, fc, fo, ci, co;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  dic_capture u_dic_capture (.clk_i, .rst_n_i, .stop_exit_i, .counter_i, .compare2_match_i(cmp_m),
    .overflow_i(ovf), .capture_pin_one_i(p1), .capture_pin_two_i(p2), .bus_rd_i(rd_s), .bus_wr_i(wr_s),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .capture_flag_one_o(f1),
    .capture_flag_two_o(f2), .compare_flag_two_o(fc), .overflow_flag_o(fo), .capture_irq_o(ci),
    .compare_irq_o(co), .timer_control_register_o(ctrl));
  dic_pin_model u_dic_pin_model (.clk_i, .pin_one_o(p1), .pin_two_o(p2));
  // ****
  // clock, watchdog, bus tasks
  // ****
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // an unknown expectation means the data is not ours to judge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    rd_s = 1'b0;
    if (!$isunknown(e)) `CHK(rdata, e)
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask
  task automatic pin(input bit two, input logic lvl, input int hold);
    u_dic_pin_model.step(two, lvl, hold);
  endtask
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    tick(16);
    rst_n_i = 1'b1;
    wr(DIC_ADDR_CTRL, 8'h80);
    rd(DIC_ADDR_CTRL, 8'h80);
    `CHK(ctrl, 8'h80)
    rd(8'h00, 8'h00);
    counter_i = 16'h1234;
    pin(1, 1'b0, 4);
    `CHK({f2, ci}, 2'b11)
    counter_i = 16'h5678;
    pin(1, 1'b1, 4);
    rd(DIC_ADDR_STATUS, 8'h10);
    rd(DIC_ADDR_CAP2_HI, 8'h12);
    rd(DIC_ADDR_CAP2_LO, 8'h35);
    `CHK(f2, 1'b0)
    counter_i = 16'h0a0b;
    pin(1, 1'b0, 4);
    pin(1, 1'b1, 2);
    counter_i = 16'h0c0d;
    pin(1, 1'b0, 4);
    rd(DIC_ADDR_CAP2_HI, 8'h0c);
    counter_i = 16'h0e0f;
    pin(1, 1'b1, 2);
    pin(1, 1'b0, 4);
    rd(DIC_ADDR_CAP2_LO, 8'h0e);
    counter_i = 16'h1111;
    pin(1, 1'b1, 2);
    pin(1, 1'b0, 4);
    rd(DIC_ADDR_CAP2_HI, 8'h11);
    wr(DIC_ADDR_CTRL, 8'h82);
    counter_i = 16'h2001;
    pin(0, 1'b0, 4);
    `CHK(f1, 1'b0)
    counter_i = 16'h2002;
    pin(0, 1'b1, 4);
    `CHK(f1, 1'b1)
    rd(DIC_ADDR_CAP1_HI, 8'h20);
    wr(DIC_ADDR_CTRL, 8'h80);
    counter_i = 16'h3003;
    pin(0, 1'b0, 4);
    rd(DIC_ADDR_CAP1_LO, 8'h03);
    pin(0, 1'b1, 2);
    pin(0, 1'b0, 4);
    rd(DIC_ADDR_CAP1_HI, 8'h30);
    rd(DIC_ADDR_STATUS, 8'h90);
    rd(DIC_ADDR_CAP1_LO, 8'h04);
    `CHK(f1, 1'b0)
    rd(DIC_ADDR_CAP1_HI, 8'h30);
    counter_i = 16'h4004;
    pin(0, 1'b1, 2);
    pin(0, 1'b0, 0);
    tick(2);
    rd(DIC_ADDR_CAP1_LO, 8'h04);
    rd(DIC_ADDR_CAP1_HI, 8'h40);
    cmp_m = 1'b1;
    tick(1);
    cmp_m = 1'b0;
    `CHK({fc, co}, 2'b10)
    wr(DIC_ADDR_CTRL, 8'hc0);
    `CHK(co, 1'b1)
    rd(DIC_ADDR_STATUS, 8'h98);
    wr(DIC_ADDR_CMP2_LO, 8'h00);
    `CHK(fc, 1'b0)
    ovf = 1'b1;
    tick(1);
    ovf = 1'b0;
    rd(DIC_ADDR_STATUS, 8'hb0);
    rd(DIC_ADDR_ACNT_LO, 8'hxx);
    `CHK(fo, 1'b1)
    rd(DIC_ADDR_STATUS, 8'hb0);
    rd(DIC_ADDR_CNT_LO, 8'hxx);
    `CHK(fo, 1'b0)
    rst_n_i = 1'b0;
    tick(3);
    rst_n_i = 1'b1;
    rd(DIC_ADDR_CAP1_HI, 8'h40);
    rd(DIC_ADDR_CAP2_LO, 8'h12);
    stop_exit_i = 1'b1;
    tick(1);
    stop_exit_i = 1'b0;
    rd(DIC_ADDR_CAP1_LO, 8'h00);
    end_of_test();
  end
endmodule
bind dic_capture dic_capture_checker u_chk (.clk_i, .rst_n_i, .compare2_match_i, .capture_pin_one_i,
  .capture_pin_two_i, .bus_rd_i, .bus_wr_i, .bus_addr_i, .capture_flag_one_o, .capture_flag_two_o,
  .compare_flag_two_o, .overflow_flag_o, .capture_irq_o, .compare_irq_o, .timer_control_register_o);
`default_nettype wire
